// ---- pkg/pwm_qtimer_pkg.sv ----
// Purpose: shared constants and types for the pwm / quadrature timer
// Assumes: 16-bit counter, plain register port with 32-bit data
// Notes: offsets are word addresses on the register port
`default_nettype none
package pwm_qtimer_pkg;
  localparam int CNT_W = 16;
  // register offsets
  localparam logic [3:0] OFS_MODE = 4'h0;   // timer_mode_reg
  localparam logic [3:0] OFS_CTRL = 4'h1;   // timer_control_reg
  localparam logic [3:0] OFS_CNT = 4'h2;    // main_counter
  localparam logic [3:0] OFS_GRA = 4'h3;    // compare_capture_a
  localparam logic [3:0] OFS_GRB = 4'h4;    // compare_capture_b
  localparam logic [3:0] OFS_MASK = 4'h5;   // phase_edge_mask_reg
  localparam logic [3:0] OFS_STAT = 4'h6;   // timer_status_reg
  localparam logic [3:0] OFS_IEN = 4'h7;    // timer_irq_enable_reg
  localparam logic [3:0] OFS_PORT = 4'h8;   // port1 dir/data bits
  // mode register bit positions
  localparam int MODE_RUN = 0;
  localparam int MODE_PWM = 1;
  localparam int MODE_PHASE = 2;
  // control register field positions
  localparam int CTRL_SRC_LSB = 0;   // count_source_sel0..2
  localparam int CTRL_EDGE_LSB = 3;  // ext_clock_edge_sel0..1
  localparam int CTRL_CLR_LSB = 5;   // counter_clear_sel0..1
  // status / enable bit positions
  localparam int ST_MATCH_A = 0;
  localparam int ST_MATCH_B = 1;
  localparam int ST_UNDER = 2;
  localparam int ST_OVER = 3;
  // port register bit positions
  localparam int PORT_WAVE_DIR = 0;
  localparam int PORT_WAVE_DAT = 1;
  localparam int PORT_CKA_DIR = 2;
  localparam int PORT_CKB_DIR = 3;
  // reset values
  localparam logic [15:0] CNT_RST = 16'h0000;
  localparam logic [15:0] GR_RST = 16'hffff;
  localparam logic [7:0] MASK_RST = 8'hff;
  localparam logic [3:0] PORT_RST = 4'hf;
  // clear source encodings
  typedef enum logic [1:0] {
    CLR_NONE = 2'h0,
    CLR_MATCH_A = 2'h1,
    CLR_MATCH_B = 2'h2,
    CLR_EXT = 2'h3
  } clr_sel_t;
  // count source encodings
  localparam logic [2:0] SRC_DIV1 = 3'h0;
  localparam logic [2:0] SRC_DIV2 = 3'h1;
  localparam logic [2:0] SRC_DIV4 = 3'h2;
  localparam logic [2:0] SRC_DIV8 = 3'h3;
  localparam logic [2:0] SRC_DIV32 = 3'h4;
  localparam logic [2:0] SRC_EXT_A = 3'h5;
  localparam logic [2:0] SRC_EXT_B = 3'h6;
  // register port request
  typedef struct packed {
    logic wr;
    logic rd;
    logic [3:0] addr;
    logic [31:0] wdata;
  } reg_req_t;
  // wave pin signals, enable low while driving
  typedef struct packed {
    logic o;
    logic oe_n;
  } pin_drv_t;
endpackage
`default_nettype wire

// ---- logic/pwm_qtimer.sv ----
// Purpose: 16-bit timer with pwm output and two-input phase counting
// Assumes: single clock mclk at 100 MHz, pins sampled by two flops
// Notes: status flags clear by writing 0, writing 1 keeps them
//
// Overview of operation
// - pwm mode: match A drives wave pin high, match B low.
// - pwm drives pin A when its dir and data bits are 0.
// - pwm idle level: high for clear on A, low for clear on B.
// - clear disabled gives a high idle pwm level.
// - idle level is loaded only while counting is stopped.
// - clear on B with A above B gives 0% duty.
// - clear on A with B above A gives 100% duty.
// - equal compare values leave the pwm level unchanged.
// - phase mode with both clock dir bits 1 uses both pins.
// - clear select, compares, status and pwm stay active in phase mode.
// - mask bits 7..4 enable the four increment edge cases.
// - mask bits 3..0 enable the four decrement edge cases.
// - edge cases with mask bit 0 do not move the counter.
// - phase mode raises match, overflow and underflow flags.
// - run bit starts and stops counting; counter stays accessible.
// - four status sources merge into one interrupt request.
// - request is high when any flag and its enable are both 1.
// - flags stay set until software writes 0 to them.
`default_nettype none
module pwm_qtimer #(
  parameter int CNT_WIDTH = 16
) (
  input wire logic mclk,
  input wire logic rstn,
  input wire pwm_qtimer_pkg::reg_req_t req,
  output logic [31:0] rdata,
  input wire logic count_input_a,
  input wire logic count_input_b,
  input wire logic wave_pin_a_in,
  output pwm_qtimer_pkg::pin_drv_t wave_pin_a,
  output logic timer_irq_request_flag
);
  // ----------------------------------------------------------------
  // reset and pin synchronisers
  // ----------------------------------------------------------------
  logic rst_s1_q, rst_n_q;
  logic [2:0] pin_s1_q, pin_s2_q;

  // release reset through two flops
  always_ff @(posedge mclk or negedge rstn) begin
    if (!rstn) begin
      rst_s1_q <= 1'b0;
      rst_n_q <= 1'b0;
    end else begin
      rst_s1_q <= 1'b1;
      rst_n_q <= rst_s1_q;
    end
  end

  // two flops on count inputs and wave pin readback
  always_ff @(posedge mclk or negedge rst_n_q) begin
    if (!rst_n_q) begin
      pin_s1_q <= 3'h0;
      pin_s2_q <= 3'h0;
    end else begin
      pin_s1_q <= {wave_pin_a_in, count_input_b, count_input_a};
      pin_s2_q <= pin_s1_q;
    end
  end

  // ----------------------------------------------------------------
  // registers
  // ----------------------------------------------------------------
  logic [2:0] mode_q;
  logic [6:0] ctrl_q;
  logic [CNT_WIDTH-1:0] cnt_q, cnt_d;
  logic [CNT_WIDTH-1:0] gra_q, grb_q;
  logic [7:0] mask_q;
  logic [3:0] stat_q, stat_d;
  logic [3:0] ien_q;
  logic [3:0] port_q;
  logic [1:0] edge_prev_q;
  logic wave_q, wave_d;
  logic [4:0] div_q;

  // write strobe aimed at one register offset
  function automatic logic wr_hit(input pwm_qtimer_pkg::reg_req_t r,
                                  input logic [3:0] ofs);
    wr_hit = r.wr && (r.addr == ofs);
  endfunction

  // writes that the counter and flag logic must see in the same cycle
  wire logic wr_cnt = wr_hit(req, pwm_qtimer_pkg::OFS_CNT);
  wire logic wr_stat = wr_hit(req, pwm_qtimer_pkg::OFS_STAT);

  // mode bits: run, pwm and phase counting
  wire logic run = mode_q[pwm_qtimer_pkg::MODE_RUN];
  wire logic pwm_on = mode_q[pwm_qtimer_pkg::MODE_PWM];
  wire logic phase_on = mode_q[pwm_qtimer_pkg::MODE_PHASE];
  wire logic [2:0] src_sel = ctrl_q[pwm_qtimer_pkg::CTRL_SRC_LSB +: 3];
  wire logic [1:0] edge_sel = ctrl_q[pwm_qtimer_pkg::CTRL_EDGE_LSB +: 2];
  // control fields: source, edge and clear select
  wire pwm_qtimer_pkg::clr_sel_t clr_sel =
    pwm_qtimer_pkg::clr_sel_t'(ctrl_q[pwm_qtimer_pkg::CTRL_CLR_LSB +: 2]);

  // control registers written from the port
  always_ff @(posedge mclk or negedge rst_n_q) begin
    if (!rst_n_q) begin
      mode_q <= 3'h0;
      ctrl_q <= 7'h00;
      gra_q <= CNT_WIDTH'(pwm_qtimer_pkg::GR_RST);
      grb_q <= CNT_WIDTH'(pwm_qtimer_pkg::GR_RST);
      mask_q <= pwm_qtimer_pkg::MASK_RST;
      ien_q <= 4'h0;
      port_q <= pwm_qtimer_pkg::PORT_RST;
    end else if (req.wr) begin
      case (req.addr)
        pwm_qtimer_pkg::OFS_MODE: mode_q <= req.wdata[2:0];
        pwm_qtimer_pkg::OFS_CTRL: ctrl_q <= req.wdata[6:0];
        pwm_qtimer_pkg::OFS_GRA: gra_q <= req.wdata[CNT_WIDTH-1:0];
        pwm_qtimer_pkg::OFS_GRB: grb_q <= req.wdata[CNT_WIDTH-1:0];
        pwm_qtimer_pkg::OFS_MASK: mask_q <= req.wdata[7:0];
        pwm_qtimer_pkg::OFS_IEN: ien_q <= req.wdata[3:0];
        pwm_qtimer_pkg::OFS_PORT: port_q <= req.wdata[3:0];
        default: ;
      endcase
    end
  end

  // ----------------------------------------------------------------
  // count enable generation
  // ----------------------------------------------------------------
  // synchronised count pins, only the second flop is read
  wire logic cka = pin_s2_q[0];
  wire logic ckb = pin_s2_q[1];

  // edge history of the synchronised clock pins
  always_ff @(posedge mclk or negedge rst_n_q) begin
    if (!rst_n_q) begin
      edge_prev_q <= 2'h0;
    end else begin
      edge_prev_q <= {ckb, cka};
    end
  end

  // single-cycle edge strobes of each pin
  wire logic a_rise = cka && !edge_prev_q[0];
  wire logic a_fall = !cka && edge_prev_q[0];
  wire logic b_rise = ckb && !edge_prev_q[1];
  wire logic b_fall = !ckb && edge_prev_q[1];

  // prescaler for internal count sources
  always_ff @(posedge mclk or negedge rst_n_q) begin
    if (!rst_n_q) begin
      div_q <= 5'h00;
    end else begin
      div_q <= div_q + 5'h01;
    end
  end

  // external edge select: rising, falling or both
  function automatic logic ext_tick(input logic r, input logic f,
                                    input logic [1:0] sel);
    unique case (sel)
      2'h0: ext_tick = r;
      2'h1: ext_tick = f;
      default: ext_tick = r | f;
    endcase
  endfunction

  // count tick outside phase mode, from prescaler or one pin
  logic norm_tick;
  always_comb begin
    unique case (src_sel)
      pwm_qtimer_pkg::SRC_DIV1: norm_tick = 1'b1;
      pwm_qtimer_pkg::SRC_DIV2: norm_tick = div_q[0:0] == 1'h1;
      pwm_qtimer_pkg::SRC_DIV4: norm_tick = div_q[1:0] == 2'h3;
      pwm_qtimer_pkg::SRC_DIV8: norm_tick = div_q[2:0] == 3'h7;
      pwm_qtimer_pkg::SRC_DIV32: norm_tick = div_q == 5'h1f;
      pwm_qtimer_pkg::SRC_EXT_A:
        norm_tick = ext_tick(a_rise, a_fall, edge_sel);
      pwm_qtimer_pkg::SRC_EXT_B:
        norm_tick = ext_tick(b_rise, b_fall, edge_sel);
      default: norm_tick = 1'b0;
    endcase
  end

  // phase decode: both pins in use once their dir bits are 1
  wire logic phase_pins = port_q[pwm_qtimer_pkg::PORT_CKA_DIR] &&
                          port_q[pwm_qtimer_pkg::PORT_CKB_DIR];
  logic [7:0] cond;
  always_comb begin
    cond[7] = b_rise && !cka;
    cond[6] = a_rise && ckb;
    cond[5] = b_fall && cka;
    cond[4] = a_fall && !ckb;
    cond[3] = a_fall && ckb;
    cond[2] = b_fall && !cka;
    cond[1] = a_rise && !ckb;
    cond[0] = b_rise && cka;
  end
  wire logic [7:0] hit = cond & mask_q;
  wire logic ph_up = phase_on && phase_pins && |hit[7:4];
  wire logic ph_dn = phase_on && phase_pins && |hit[3:0];

  // ----------------------------------------------------------------
  // counter, matches and clears
  // ----------------------------------------------------------------
  // step direction; opposite steps in one cycle cancel
  wire logic step_up = run && (phase_on ? ph_up && !ph_dn : norm_tick);
  wire logic step_dn = run && phase_on && ph_dn && !ph_up;
  // matches only on a step, so a stopped counter raises nothing
  wire logic max_v = &cnt_q;
  wire logic zero_v = ~|cnt_q;
  wire logic match_a = (step_up || step_dn) && cnt_q == gra_q;
  wire logic match_b = (step_up || step_dn) && cnt_q == grb_q;
  wire logic ovf = step_up && max_v;
  wire logic underflow_flag = step_dn && zero_v;

  // next counter value; compare clears apply in all modes
  always_comb begin
    cnt_d = cnt_q;
    if (wr_cnt) begin
      cnt_d = req.wdata[CNT_WIDTH-1:0];
    end else if ((clr_sel == pwm_qtimer_pkg::CLR_MATCH_A && match_a) ||
                 (clr_sel == pwm_qtimer_pkg::CLR_MATCH_B && match_b)) begin
      cnt_d = '0;
    end else if (step_up) begin
      cnt_d = cnt_q + CNT_WIDTH'(1);
    end else if (step_dn) begin
      cnt_d = cnt_q - CNT_WIDTH'(1);
    end
  end

  // counter register
  always_ff @(posedge mclk or negedge rst_n_q) begin
    if (!rst_n_q) begin
      cnt_q <= CNT_WIDTH'(pwm_qtimer_pkg::CNT_RST);
    end else begin
      cnt_q <= cnt_d;
    end
  end

  // ----------------------------------------------------------------
  // status flags: set wins, write 0 clears, write 1 keeps
  // ----------------------------------------------------------------
  logic [3:0] set_v;
  always_comb begin
    set_v = 4'h0;
    set_v[pwm_qtimer_pkg::ST_MATCH_A] = match_a;
    set_v[pwm_qtimer_pkg::ST_MATCH_B] = match_b;
    set_v[pwm_qtimer_pkg::ST_UNDER] = underflow_flag;
    set_v[pwm_qtimer_pkg::ST_OVER] = ovf;
    stat_d = stat_q;
    if (wr_stat) begin
      stat_d = stat_q & req.wdata[3:0];
    end
    stat_d = stat_d | set_v;
  end

  // status register
  always_ff @(posedge mclk or negedge rst_n_q) begin
    if (!rst_n_q) begin
      stat_q <= 4'h0;
    end else begin
      stat_q <= stat_d;
    end
  end

  // one merged request from the four gated flags
  assign timer_irq_request_flag = |(stat_q & ien_q);

  // ----------------------------------------------------------------
  // pwm waveform
  // ----------------------------------------------------------------
  // level the pin returns to while the count is stopped
  logic idle_lvl;
  always_comb begin
    unique case (clr_sel)
      pwm_qtimer_pkg::CLR_MATCH_B: idle_lvl = 1'b0;
      default: idle_lvl = 1'b1;
    endcase
  end

  // set on A, reset on B; equal compares hold; idle level when stopped
  always_comb begin
    wave_d = wave_q;
    if (!run) begin
      wave_d = idle_lvl;
    end else if (gra_q == grb_q) begin
      wave_d = wave_q;
    end else if (match_b) begin
      wave_d = 1'b0;
    end else if (match_a) begin
      wave_d = 1'b1;
    end
  end

  // waveform level register, high out of reset
  always_ff @(posedge mclk or negedge rst_n_q) begin
    if (!rst_n_q) begin
      wave_q <= 1'b1;
    end else begin
      wave_q <= wave_d;
    end
  end

  // pin A carries pwm only when dir and data bits are both 0
  wire logic pwm_pin = pwm_on && !port_q[pwm_qtimer_pkg::PORT_WAVE_DIR] &&
                       !port_q[pwm_qtimer_pkg::PORT_WAVE_DAT];
  assign wave_pin_a.o = wave_q;
  assign wave_pin_a.oe_n = !pwm_pin;

  // ----------------------------------------------------------------
  // read port, data one cycle after the strobe
  // ----------------------------------------------------------------
  // read selection, narrow fields in the low bits
  logic [31:0] rd_mux;
  always_comb begin
    rd_mux = 32'h0;
    unique case (req.addr)
      pwm_qtimer_pkg::OFS_MODE: rd_mux[2:0] = mode_q;
      pwm_qtimer_pkg::OFS_CTRL: rd_mux[6:0] = ctrl_q;
      pwm_qtimer_pkg::OFS_CNT: rd_mux[CNT_WIDTH-1:0] = cnt_q;
      pwm_qtimer_pkg::OFS_GRA: rd_mux[CNT_WIDTH-1:0] = gra_q;
      pwm_qtimer_pkg::OFS_GRB: rd_mux[CNT_WIDTH-1:0] = grb_q;
      pwm_qtimer_pkg::OFS_MASK: rd_mux[7:0] = mask_q;
      pwm_qtimer_pkg::OFS_STAT: rd_mux[3:0] = stat_q;
      pwm_qtimer_pkg::OFS_IEN: rd_mux[3:0] = ien_q;
      pwm_qtimer_pkg::OFS_PORT: rd_mux = {27'h0, pin_s2_q[2], port_q};
      default: rd_mux = 32'h0;
    endcase
  end

  // read data stands one cycle, zero otherwise
  always_ff @(posedge mclk or negedge rst_n_q) begin
    if (!rst_n_q) begin
      rdata <= 32'h0;
    end else if (req.rd) begin
      rdata <= rd_mux;
    end else begin
      rdata <= 32'h0;
    end
  end
endmodule
`default_nettype wire

// ---- verif/pwm_qtimer_chk.sv ----
// Purpose: port checker for the pwm / quadrature timer
// Assumes: writes land one cycle after the strobe
// Notes: shadows written registers to judge the outputs
`default_nettype none
module pwm_qtimer_chk #(
  parameter int CNT_WIDTH = 16
) (
  input wire logic mclk,
  input wire logic rstn,
  input wire pwm_qtimer_pkg::reg_req_t req,
  input wire logic [31:0] rdata,
  input wire logic count_input_a,
  input wire logic count_input_b,
  input wire logic wave_pin_a_in,
  input wire pwm_qtimer_pkg::pin_drv_t wave_pin_a,
  input wire logic timer_irq_request_flag
);
  timeunit 1ns;
  timeprecision 1ps;
  logic [2:0] mode_q;
  logic [1:0] clr_q, quiet_q;
  logic [3:0] port_q, ien_q;
  logic [15:0] gra_q, grb_q;
  logic calm, pwm, run;
  // shadow copies of the written registers
  always_ff @(posedge mclk or negedge rstn) begin
    if (!rstn) begin
      mode_q <= 3'h0;
      clr_q <= 2'h0;
      port_q <= 4'hf;
      ien_q <= 4'h0;
      gra_q <= 16'hffff;
      grb_q <= 16'hffff;
    end else if (req.wr) begin
      case (req.addr)
        pwm_qtimer_pkg::OFS_MODE: mode_q <= req.wdata[2:0];
        pwm_qtimer_pkg::OFS_CTRL: clr_q <= req.wdata[6:5];
        pwm_qtimer_pkg::OFS_GRA: gra_q <= req.wdata[15:0];
        pwm_qtimer_pkg::OFS_GRB: grb_q <= req.wdata[15:0];
        pwm_qtimer_pkg::OFS_IEN: ien_q <= req.wdata[3:0];
        pwm_qtimer_pkg::OFS_PORT: port_q <= req.wdata[3:0];
        default: ;
      endcase
    end
  end
  // cycles since the last write, saturating
  always_ff @(posedge mclk or negedge rstn) begin
    if (!rstn) begin
      quiet_q <= 2'h0;
    end else if (req.wr) begin
      quiet_q <= 2'h0;
    end else if (quiet_q != 2'h3) begin
      quiet_q <= quiet_q + 2'h1;
    end
  end
  assign calm = quiet_q == 2'h3;
  assign pwm = mode_q[1];
  assign run = mode_q[0];
  default clocking cb @(posedge mclk); endclocking
  default disable iff (!rstn);
  property p_drive;
    calm |-> wave_pin_a.oe_n == !(pwm && port_q[1:0] == 2'h0);
  endproperty
  a_drive: assert property (p_drive)
    else $error("wave pin enable wrong");
  property p_idle;
    calm && pwm && !run |-> wave_pin_a.o == (clr_q != 2'h2);
  endproperty
  a_idle: assert property (p_idle)
    else $error("idle level wrong");
  property p_zero;
    calm && pwm && run && clr_q == 2'h2 && gra_q > grb_q |-> !wave_pin_a.o;
  endproperty
  a_zero: assert property (p_zero)
    else $error("zero duty broken");
  property p_full;
    calm && pwm && run && clr_q == 2'h1 && grb_q > gra_q |-> wave_pin_a.o;
  endproperty
  a_full: assert property (p_full)
    else $error("full duty broken");
  property p_equal;
    calm && pwm && run && gra_q == grb_q |-> $stable(wave_pin_a.o);
  endproperty
  a_equal: assert property (p_equal)
    else $error("level moved on equal compares");
  property p_irq_off;
    calm && ien_q == 4'h0 |-> !timer_irq_request_flag;
  endproperty
  a_irq_off: assert property (p_irq_off)
    else $error("request without enable");
  property p_irq_hold;
    $fell(timer_irq_request_flag) |-> $past(req.wr) || $past(req.wr, 2);
  endproperty
  a_irq_hold: assert property (p_irq_hold)
    else $error("request dropped without write");
  property p_rdata;
    !$past(req.rd) |-> rdata == 32'h0;
  endproperty
  a_rdata: assert property (p_rdata)
    else $error("read data outside its cycle");
  c_rise: cover property (pwm && run && $rose(wave_pin_a.o));
  c_irq: cover property ($rose(timer_irq_request_flag));
  c_drive: cover property ($fell(wave_pin_a.oe_n));
endmodule
bind pwm_qtimer pwm_qtimer_chk #(.CNT_WIDTH(CNT_WIDTH)) u_chk (
  .mclk(mclk),
  .rstn(rstn),
  .req(req),
  .rdata(rdata),
  .count_input_a(count_input_a),
  .count_input_b(count_input_b),
  .wave_pin_a_in(wave_pin_a_in),
  .wave_pin_a(wave_pin_a),
  .timer_irq_request_flag(timer_irq_request_flag)
);
`default_nettype wire

// ---- verif/qenc_model.sv ----
// Purpose: quadrature encoder and wave pin load
// Assumes: steps spaced far above the minimum pulse width
// Notes: pin has a pull-up while the timer releases it
`default_nettype none
module qenc_model (
  input wire logic mclk,
  output logic a,
  output logic b,
  input wire pwm_qtimer_pkg::pin_drv_t drv,
  output logic pin_in
);
  timeunit 1ns;
  timeprecision 1ps;
  logic [1:0] idx = 2'h0;
  // gray order 00,01,11,10 (a,b) counts up
  assign a = idx[1];
  assign b = idx[1] ^ idx[0];
  assign pin_in = drv.oe_n ? 1'b1 : drv.o;
  // one encoder step, then a long settle
  task automatic step(input logic up);
    @(posedge mclk);
    idx <= up ? idx + 2'h1 : idx - 2'h1;
    repeat (8) @(posedge mclk);
  endtask
endmodule
`default_nettype wire

// ---- verif/testbench.sv ----
// Purpose: self-checking bench for the pwm / quadrature timer
// Assumes: register port with read data one cycle later
// Notes: pwm cases from a table, phase cases per mask
`default_nettype none
module testbench;
  timeunit 1ns;
  timeprecision 1ps;
  logic mclk, rstn, cka, ckb, pin_in, irq;
  pwm_qtimer_pkg::reg_req_t req;
  pwm_qtimer_pkg::pin_drv_t wave;
  logic [31:0] rdata, d;
  logic [15:0] exp;
  logic [7:0] m;
  int num_errors, tests_run, hi;
  localparam logic [31:0] RST [10] = '{0, 0, 0, 'hffff, 'hffff, 'hff, 0,
    0, 'h1f, 0};
  localparam logic [1:0] PC [5] = '{2'h2, 2'h1, 2'h2, 2'h1, 2'h2};
  localparam int PA [5] = '{2, 2, 9, 5, 5};
  localparam int PB [5] = '{9, 9, 2, 5, 5};
  localparam int PH [5] = '{70, 100, 0, 100, 0};
  localparam int RB [4] = '{1, 0, 3, 2};
  localparam logic [7:0] MK [4] = '{8'hff, 8'h00, 8'h5a, 8'ha5};
  always #5 mclk = ~mclk;
  pwm_qtimer #(.CNT_WIDTH(16)) u_dut (
    .mclk(mclk),
    .rstn(rstn),
    .req(req),
    .rdata(rdata),
    .count_input_a(cka),
    .count_input_b(ckb),
    .wave_pin_a_in(pin_in),
    .wave_pin_a(wave),
    .timer_irq_request_flag(irq)
  );
  qenc_model u_enc (.mclk(mclk), .a(cka), .b(ckb), .drv(wave),
    .pin_in(pin_in));
  task automatic give_verdict();
    $display("errors %0d checks %0d", num_errors, tests_run);
    if (num_errors == 0 && tests_run > 0) begin
      $display("DONE - PASS");
    end else begin
      $display("DONE - FAIL");
    end
    $finish;
  endtask
  task automatic chk(input logic [31:0] got, input logic [31:0] want);
    tests_run++;
    if (got !== want) begin
      num_errors++;
      $display("[FAIL] %0t got %h want %h", $time, got, want);
    end
  endtask
  task automatic wr(input logic [3:0] a, input logic [31:0] v);
    @(posedge mclk);
    req <= '{wr: 1'b1, rd: 1'b0, addr: a, wdata: v};
    @(posedge mclk);
    req <= '0;
    #1;
  endtask
  task automatic rd(input logic [3:0] a, output logic [31:0] v);
    @(posedge mclk);
    req <= '{wr: 1'b0, rd: 1'b1, addr: a, wdata: 32'h0};
    @(posedge mclk);
    req <= '0;
    #1 v = rdata;
  endtask
  // watchdog against a hang
  initial begin
    #200000;
    num_errors++;
    give_verdict();
  end
  initial begin
    mclk = 1'b0;
    rstn = 1'b0;
    req = '0;
    num_errors = 0;
    tests_run = 0;
    repeat (10) @(posedge mclk);
    rstn <= 1'b1;
    repeat (3) @(posedge mclk);
    // reset values and the unmapped offset
    for (int i = 0; i < 10; i++) begin
      rd(i[3:0], d);
      chk(d, RST[i]);
    end
    chk(wave, 32'h3);
    // counter access, wrap and status flags
    wr(pwm_qtimer_pkg::OFS_CNT, 32'hfffe);
    rd(pwm_qtimer_pkg::OFS_CNT, d);
    chk(d, 32'hfffe);
    wr(pwm_qtimer_pkg::OFS_MODE, 32'h1);
    rd(pwm_qtimer_pkg::OFS_CNT, d);
    wr(pwm_qtimer_pkg::OFS_MODE, 32'h0);
    rd(pwm_qtimer_pkg::OFS_CNT, d);
    chk(d < 32'h10, 32'h1);
    exp = d[15:0];
    repeat (5) @(posedge mclk);
    rd(pwm_qtimer_pkg::OFS_CNT, d);
    chk(d, {16'h0, exp});
    rd(pwm_qtimer_pkg::OFS_STAT, d);
    chk(d, 32'hb);
    chk(irq, 32'h0);
    wr(pwm_qtimer_pkg::OFS_IEN, 32'h8);
    chk(irq, 32'h1);
    wr(pwm_qtimer_pkg::OFS_STAT, 32'hf);
    rd(pwm_qtimer_pkg::OFS_STAT, d);
    chk(d, 32'hb);
    chk(irq, 32'h1);
    wr(pwm_qtimer_pkg::OFS_STAT, 32'h1);
    rd(pwm_qtimer_pkg::OFS_STAT, d);
    chk(d, 32'h1);
    chk(irq, 32'h0);
    wr(pwm_qtimer_pkg::OFS_IEN, 32'h1);
    chk(irq, 32'h1);
    wr(pwm_qtimer_pkg::OFS_IEN, 32'h0);
    wr(pwm_qtimer_pkg::OFS_STAT, 32'h0);
    rd(pwm_qtimer_pkg::OFS_STAT, d);
    chk(d, 32'h0);
    // pwm cases, set up in the documented order
    wr(pwm_qtimer_pkg::OFS_PORT, 32'h0);
    for (int i = 0; i < 5; i++) begin
      wr(pwm_qtimer_pkg::OFS_MODE, 32'h2);
      wr(pwm_qtimer_pkg::OFS_CTRL, {25'h0, PC[i], 5'h0});
      wr(pwm_qtimer_pkg::OFS_GRA, PA[i]);
      wr(pwm_qtimer_pkg::OFS_GRB, PB[i]);
      wr(pwm_qtimer_pkg::OFS_CNT, 32'h0);
      repeat (5) @(negedge mclk);
      chk(wave, {PC[i] != 2'h2, 1'b0});
      wr(pwm_qtimer_pkg::OFS_MODE, 32'h3);
      repeat (20) @(negedge mclk);
      hi = 0;
      repeat (100) begin
        @(negedge mclk);
        hi += wave.o;
      end
      chk(hi, PH[i]);
    end
    // phase counting for each mask
    wr(pwm_qtimer_pkg::OFS_MODE, 32'h0);
    wr(pwm_qtimer_pkg::OFS_PORT, 32'hc);
    wr(pwm_qtimer_pkg::OFS_MODE, 32'h4);
    for (int k = 0; k < 4; k++) begin
      m = MK[k];
      wr(pwm_qtimer_pkg::OFS_STAT, 32'h0);
      wr(pwm_qtimer_pkg::OFS_MASK, m);
      wr(pwm_qtimer_pkg::OFS_CNT, 32'h0);
      wr(pwm_qtimer_pkg::OFS_MODE, 32'h5);
      exp = 16'h0;
      for (int j = 0; j < 4; j++) begin
        u_enc.step(1'b0);
        exp -= 16'(m[RB[j]]);
        rd(pwm_qtimer_pkg::OFS_CNT, d);
        chk(d, exp);
      end
      for (int j = 0; j < 4; j++) begin
        u_enc.step(1'b1);
        exp += 16'(m[7 - j]);
        rd(pwm_qtimer_pkg::OFS_CNT, d);
        chk(d, exp);
      end
      wr(pwm_qtimer_pkg::OFS_MODE, 32'h4);
      rd(pwm_qtimer_pkg::OFS_STAT, d);
      chk(d, m != 8'h0 ? 32'hc : 32'h0);
    end
    u_enc.step(1'b1);
    rd(pwm_qtimer_pkg::OFS_CNT, d);
    chk(d, 32'h0);
    give_verdict();
  end
endmodule
`default_nettype wire
